// *** rtl/fcs_flash_cmd_status.sv ***
// Chosen here: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

module fcs_flash_cmd_status
    import fcs_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic [15:0] adr_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    input wire logic we_i,
    input wire logic [3:0] sel_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    output logic ack_o,
    input wire logic special_mode_i,
    input wire logic cpu_stop_i,
    input wire logic prot_hit_i,
    input wire logic op_done_i,
    input wire logic verify_blank_i,
    output fcs_job_type job_o,
    output logic start_o,
    output logic be_irq_o,
    output logic cc_irq_o
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic ack_r, prot_r, buf_v_r, active_r, start_r;
    logic [31:0] dat_r;
    fcs_seq_type seq_r, seq_nxt;
    logic [7:0] cfg_r, cmd_r;
    logic [12:0] addr_r;
    logic [15:0] data_r;
    fcs_job_type buf_r, job_r;
    logic be_r, cc_r, pv_r, ae_r, blank_r, fail_r;
    logic be_irq_r, cc_irq_r;
    // ------------------------------------------------------------------
    // bus decode
    // ------------------------------------------------------------------
    logic req, wr, reg_sel, arr_wr, st_wr, cmd_wr, cfg_wr;
    logic [3:0] idx;
    logic [7:0] wd, cmd_code;
    logic cmd_ok, errs, launch_req, go, bad_cmd, prot_fail;
    logic seq_viol, acc_set, fetch, finish;

    // a request is served once; the ack cycle itself is not a new request
    assign req = cyc_i & stb_i & ~ack_r;
    assign wr = req & we_i;
    assign idx = adr_i[5:2];
    assign reg_sel = ~adr_i[BIT_ARRAY] & (adr_i[14:6] == 9'h000);
    assign wd = dat_i[7:0];

    // the array takes aligned 16-bit words on the low lanes only
    assign arr_wr = wr & adr_i[BIT_ARRAY] & (sel_i == 4'h3);
    assign st_wr = wr & reg_sel & (idx == IDX_STATUS) & sel_i[0];
    assign cmd_wr = wr & reg_sel & (idx == IDX_COMMAND) & sel_i[0];
    assign cfg_wr = wr & reg_sel & (idx == IDX_CONFIG) & sel_i[0];

    // ------------------------------------------------------------------
    // launch qualification
    // ------------------------------------------------------------------
    assign cmd_code = cmd_r & CMD_MASK;
    assign cmd_ok = (cmd_code == CMD_VERIFY) | (cmd_code == CMD_PROGRAM)
                  | (cmd_code == CMD_SECTOR) | (cmd_code == CMD_MASS);
    assign errs = pv_r | ae_r | fail_r;
    assign launch_req = st_wr & wd[BIT_BE] & be_r & (seq_r == SEQ_CMD);
    assign go = launch_req & ~errs & cmd_ok & ~prot_fail;
    assign bad_cmd = launch_req & ~errs & ~cmd_ok;
    // verify touches nothing, so only program and erase can violate
    assign prot_fail = launch_req & ~errs & cmd_ok & prot_r
                     & (cmd_code != CMD_VERIFY);

    // a status, command, config or array write that breaks the three-step order
    always_comb begin
        seq_viol = 1'b0;
        if (st_wr && !wd[BIT_BE] && seq_r != SEQ_IDLE) begin
            seq_viol = 1'b1;
        end
        if (st_wr && wd[BIT_BE] && seq_r == SEQ_ADDR) begin
            seq_viol = 1'b1;
        end
        if (cmd_wr && seq_r != SEQ_ADDR) begin
            seq_viol = 1'b1;
        end
        if ((arr_wr || cfg_wr) && seq_r != SEQ_IDLE) begin
            seq_viol = 1'b1;
        end
    end

    // stop while a command runs is an error too
    assign acc_set = seq_viol | bad_cmd | (cpu_stop_i & ~cc_r);
    assign fetch = buf_v_r & (~active_r | op_done_i);
    assign finish = active_r & op_done_i;

    // ------------------------------------------------------------------
    // wishbone answer: one wait state, registered data
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_r <= 1'b0;
        end else begin
            ack_r <= req;
        end
    end

    // read mux; unmapped and reserved words read zero
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_r <= 32'h0000_0000;
        end else if (req && !we_i) begin
            dat_r <= 32'h0000_0000;
            if (reg_sel && idx == IDX_STATUS) begin
                dat_r[BIT_BE] <= be_r;
                dat_r[BIT_CC] <= cc_r;
                dat_r[BIT_PV] <= pv_r;
                dat_r[BIT_AE] <= ae_r;
                dat_r[BIT_BLANK] <= blank_r;
                dat_r[BIT_FAIL] <= special_mode_i & fail_r;
                dat_r[BIT_DONE] <= special_mode_i & ~active_r;
            end else if (reg_sel && idx == IDX_COMMAND) begin
                dat_r[7:0] <= cmd_r & CMD_MASK;
            end else if (reg_sel && idx == IDX_CONFIG) begin
                dat_r[7:0] <= cfg_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // command write sequence
    // ------------------------------------------------------------------
    always_comb begin
        seq_nxt = seq_r;
        unique case (seq_r)
            SEQ_IDLE: begin
                // a full buffer cannot take a new sequence; it is ignored
                if (arr_wr && be_r) begin
                    seq_nxt = SEQ_ADDR;
                end
            end
            SEQ_ADDR: begin
                if (cmd_wr) begin
                    seq_nxt = SEQ_CMD;
                end
            end
            SEQ_CMD: begin
                if (launch_req) begin
                    seq_nxt = SEQ_IDLE;
                end
            end
        endcase
        if (seq_viol || bad_cmd) begin
            seq_nxt = SEQ_IDLE;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            seq_r <= SEQ_IDLE;
        end else begin
            seq_r <= seq_nxt;
        end
    end

    // address, data and protection hit of the first step
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            addr_r <= 13'h0000;
            data_r <= 16'h0000;
            prot_r <= 1'b0;
        end else if (arr_wr && be_r && seq_r == SEQ_IDLE) begin
            addr_r <= adr_i[14:2];
            data_r <= dat_i[15:0];
            prot_r <= prot_hit_i;
        end
    end

    // only the four implemented command bits are stored
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cmd_r <= RST_COMMAND;
        end else if (cmd_wr && seq_r == SEQ_ADDR) begin
            cmd_r <= wd & CMD_MASK;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cfg_r <= RST_CONFIG;
        end else if (cfg_wr && seq_r == SEQ_IDLE) begin
            cfg_r <= wd & 8'hc0;
        end
    end

    // ------------------------------------------------------------------
    // two-stage pipe: buffered job, then active job
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            buf_v_r <= 1'b0;
            buf_r <= '0;
        end else if (go) begin
            buf_v_r <= 1'b1;
            buf_r <= '{cmd: cmd_code, addr: addr_r, data: data_r};
        end else if (fetch) begin
            buf_v_r <= 1'b0;
        end
    end

    // a buffered job waits for the active one to finish
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            active_r <= 1'b0;
            start_r <= 1'b0;
            job_r <= '0;
        end else begin
            start_r <= fetch;
            if (fetch) begin
                active_r <= 1'b1;
                job_r <= buf_r;
            end else if (finish) begin
                active_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // status flags; a hardware set wins over a same-cycle clear, except complete, which a same-cycle launch clears
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            be_r <= RST_BE;
        end else if (fetch) begin
            be_r <= 1'b1;
        end else if (go) begin
            be_r <= 1'b0;
        end
    end

    // a chained fetch does not raise complete
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cc_r <= RST_CC;
        end else if (go) begin
            cc_r <= 1'b0;
        end else if (finish && !buf_v_r) begin
            cc_r <= 1'b1;
        end
    end

    // one status write clears each of the pv and ae flags it holds a one for
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pv_r <= 1'b0;
            ae_r <= 1'b0;
        end else begin
            pv_r <= prot_fail | (pv_r & ~(st_wr & wd[BIT_PV]));
            ae_r <= acc_set | (ae_r & ~(st_wr & wd[BIT_AE]));
        end
    end

    // verify result; blank drops when a valid launch takes place
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            blank_r <= 1'b0;
            fail_r <= 1'b0;
        end else begin
            if (finish && job_r.cmd == CMD_VERIFY && verify_blank_i) begin
                blank_r <= 1'b1;
            end else if (go) begin
                blank_r <= 1'b0;
            end
            if (finish && job_r.cmd == CMD_VERIFY && !verify_blank_i
                && special_mode_i) begin
                fail_r <= 1'b1;
            end else if (st_wr && wd[BIT_FAIL] && special_mode_i) begin
                fail_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // interrupt requests, registered to keep outputs glitch free
    // ------------------------------------------------------------------
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            be_irq_r <= 1'b0;
            cc_irq_r <= 1'b0;
        end else begin
            be_irq_r <= be_r & cfg_r[BIT_BE_IE];
            cc_irq_r <= cc_r & cfg_r[BIT_CC_IE];
        end
    end

    assign ack_o = ack_r;
    assign dat_o = dat_r;
    assign job_o = job_r;
    assign start_o = start_r;
    assign be_irq_o = be_irq_r;
    assign cc_irq_o = cc_irq_r;

    // ------------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i);
    endclocking
    default disable iff (rst_i);

    a_launch_clears:
        assert property (go |=> !cc_r && !be_r && buf_v_r)
        else $error("launch did not clear complete and buffer empty");
    a_refill_empty:
        assert property (buf_v_r && !active_r |=> be_r && start_r
                         && active_r)
        else $error("buffered job not fetched or buffer empty not set");
    a_chain_fetch:
        assert property (finish && buf_v_r |=> !cc_r ##0 start_r)
        else $error("chained fetch raised complete");
    // a launch in the finishing cycle leaves a job pending, so no complete
    a_last_done:
        assert property (finish && !buf_v_r && !go |=> cc_r && !active_r)
        else $error("complete not set after last job");
    a_bad_code:
        assert property (bad_cmd |=> ae_r && !buf_v_r
                         && seq_r == SEQ_IDLE)
        else $error("undefined command not refused");
    a_error_block:
        assert property (launch_req && errs |=> !buf_v_r && !start_r)
        else $error("launch taken while an error flag was set");
    a_zero_abort:
        assert property (st_wr && !wd[BIT_BE] && seq_r != SEQ_IDLE
                         |=> ae_r && seq_r == SEQ_IDLE)
        else $error("zero write mid-sequence did not abort");
    a_zero_idle:
        assert property (st_wr && !wd[BIT_BE] && seq_r == SEQ_IDLE
                         && !ae_r && !(cpu_stop_i && !cc_r)
                         |=> !ae_r)
        else $error("zero write outside sequence set access error");
    a_irq_follow:
        assert property (be_r && cfg_r[BIT_BE_IE] |=> be_irq_o)
        else $error("buffer empty irq missing");
    a_cc_irq:
        assert property (!cc_r |=> !cc_irq_o)
        else $error("complete irq without complete flag");
    a_multi_clear:
        assert property (st_wr && wd[BIT_PV] && wd[BIT_AE] && !acc_set
                         && !prot_fail |=> !pv_r && !ae_r)
        else $error("flags not cleared together");
    a_cmd_bits:
        assert property (req && !we_i && reg_sel && idx == IDX_COMMAND
                         |=> (dat_o[7:0] & ~CMD_MASK) == 8'h00
                         && ack_o)
        else $error("unimplemented command bits read nonzero");
    a_rsvd_zero:
        assert property (req && !we_i && reg_sel && idx == IDX_RSVD
                         |=> dat_o == 32'h0000_0000)
        else $error("reserved register read nonzero");
    a_done_bit:
        assert property (req && !we_i && reg_sel && idx == IDX_STATUS
                         && special_mode_i
                         |=> dat_o[BIT_DONE] == !$past(active_r))
        else $error("done bit does not follow activity");
    c_launch: cover property (go ##[1:20] finish);
    c_chain: cover property (finish && buf_v_r);
    c_bad_code: cover property (bad_cmd);
    c_prot: cover property (prot_fail);

endmodule

`default_nettype wire

// *** common/fcs_pkg.sv ***
package fcs_pkg;

    // ------------------------------------------------------------------
    // register map: word indices, byte address is four times the index
    // ------------------------------------------------------------------
    localparam logic [3:0] IDX_CONFIG = 4'h3;
    localparam logic [3:0] IDX_STATUS = 4'h5;
    localparam logic [3:0] IDX_COMMAND = 4'h6;
    localparam logic [3:0] IDX_RSVD = 4'h7;

    // ------------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------------
    localparam int BIT_BE = 7;
    localparam int BIT_CC = 6;
    localparam int BIT_PV = 5;
    localparam int BIT_AE = 4;
    localparam int BIT_BLANK = 2;
    localparam int BIT_FAIL = 1;
    localparam int BIT_DONE = 0;
    localparam int BIT_BE_IE = 7;
    localparam int BIT_CC_IE = 6;
    localparam int BIT_ARRAY = 15;

    // ------------------------------------------------------------------
    // command codes and implemented command bits
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_MASK = 8'h65;
    localparam logic [7:0] CMD_VERIFY = 8'h05;
    localparam logic [7:0] CMD_PROGRAM = 8'h20;
    localparam logic [7:0] CMD_SECTOR = 8'h40;
    localparam logic [7:0] CMD_MASS = 8'h41;

    // ------------------------------------------------------------------
    // values after reset
    // ------------------------------------------------------------------
    localparam logic RST_BE = 1'b1;
    localparam logic RST_CC = 1'b1;
    localparam logic [7:0] RST_CONFIG = 8'h00;
    localparam logic [7:0] RST_COMMAND = 8'h00;

    // command write sequence progress
    typedef enum logic [1:0] {
        SEQ_IDLE,
        SEQ_ADDR,
        SEQ_CMD
    } fcs_seq_type;

    // one buffered or active job for the program/erase engine
    typedef struct packed {
        logic [7:0] cmd;
        logic [12:0] addr;
        logic [15:0] data;
    } fcs_job_type;

endpackage

// *** verification/fcs_engine_model.sv ***
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// program/erase engine stand-in
// ------------------------------------------------------------
module fcs_engine_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] delay_i,
    input wire logic blank_i,
    output logic done_o,
    output logic blank_o
);
    logic busy_r;
    logic [7:0] cnt_r;
    // one job at a time, finishing delay_i+1 cycles after its start
    always_ff @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            busy_r <= 1'b0;
            cnt_r <= 8'h00;
        end else if (start_i) begin
            busy_r <= 1'b1;
            cnt_r <= delay_i;
        end else if (busy_r) begin
            if (cnt_r == 8'h00) begin
                busy_r <= 1'b0;
                done_o <= 1'b1;
            end else begin
                cnt_r <= cnt_r - 8'h01;
            end
        end
    end
    // verdict inverted outside done, so a late sample reads it wrong
    assign blank_o = done_o ? blank_i : ~blank_i;
endmodule
`default_nettype wire

// *** verification/test_fcs_flash_cmd_status.sv ***
`timescale 1ns/1ps
`default_nettype none
module test_fcs_flash_cmd_status;
    import fcs_pkg::*;
    // ------------------------------------------------------------
    // signals
    // ------------------------------------------------------------
    localparam logic [15:0] A_CF = 16'h000c;
    localparam logic [15:0] A_ST = 16'h0014;
    localparam logic [15:0] A_CM = 16'h0018;
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [15:0] adr = 16'h0000;
    logic [31:0] wdat = 32'h0;
    logic [3:0] sel = 4'h0;
    logic we = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic spec = 1'b0;
    logic stop = 1'b0;
    logic prot = 1'b0;
    logic blank = 1'b0;
    logic [7:0] dly = 8'h04;
    logic [31:0] dat_o;
    logic ack_o, start_o, be_irq_o, cc_irq_o, done, vblank;
    fcs_job_type job_o;
    fcs_job_type last_job;
    logic [39:0] rd;
    logic [7:0] codes [6] = '{8'h05, 8'h20, 8'h40, 8'h41, 8'hff, 8'h01};
    int n_fail = 0;
    int n_tests = 0;
    int n_start = 0;

    fcs_flash_cmd_status fcs_flash_cmd_status_inst (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(wdat),
        .dat_o(dat_o), .we_i(we), .sel_i(sel), .cyc_i(cyc), .stb_i(stb),
        .ack_o(ack_o), .special_mode_i(spec), .cpu_stop_i(stop),
        .prot_hit_i(prot), .op_done_i(done), .verify_blank_i(vblank),
        .job_o(job_o), .start_o(start_o), .be_irq_o(be_irq_o),
        .cc_irq_o(cc_irq_o)
    );
    fcs_engine_model fcs_engine_model_inst (
        .clk_i(clk_i), .rst_i(rst_i), .start_i(start_o), .delay_i(dly),
        .blank_i(blank), .done_o(done), .blank_o(vblank)
    );

    // clock and engine start monitor
    initial begin
        forever #20 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        if (start_o === 1'b1) begin
            n_start <= n_start + 1;
            last_job <= job_o;
        end
    end

    // ------------------------------------------------------------
    // bus and compare tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [39:0] got, input logic [39:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("wrong value at %0t: got %h exp %h", $time, got, exp);
        end
    endtask
    // classic cycle, held until ack is sampled; no latency assumed
    task automatic wb(input logic w, input logic [15:0] a,
                      input logic [31:0] d);
        int i;
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel <= a[15] ? 4'h3 : 4'h1;
        for (i = 0; i < 50; i++) begin
            @(posedge clk_i);
            if (ack_o === 1'b1) break;
        end
        chk({39'h0, ack_o}, 40'h1);
        rd = {8'h0, dat_o};
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task automatic rdc(input logic [15:0] a, input logic [39:0] e);
        wb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    // address, command, launch, nothing else between
    task automatic launch(input logic [15:0] a, input logic [15:0] d,
                          input logic [7:0] c);
        wb(1'b1, a, {16'h0, d});
        wb(1'b1, A_CM, {24'h0, c});
        wb(1'b1, A_ST, 32'h80);
    endtask
    task automatic wait_cc();
        int i;
        for (i = 0; i < 100; i++) begin
            wb(1'b0, A_ST, 32'h0);
            if (rd[BIT_CC] === 1'b1) break;
        end
    endtask
    task automatic wrap_up();
        $display("tests %0d failures %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_reset();
        rdc(A_ST, 40'hc0);
        rdc(A_CM, 40'h0);
        rdc(A_CF, 40'h0);
        wb(1'b1, 16'h001c, 32'hff);
        rdc(16'h001c, 40'h0);
        rdc(16'h0040, 40'h0);
        wb(1'b1, A_ST, 32'h4f);
        rdc(A_ST, 40'hc0);
    endtask
    task automatic t_prog();
        int s;
        s = n_start;
        dly <= 8'd20;
        launch(16'h8010, 16'h1234, CMD_PROGRAM);
        rdc(A_ST, 40'h80);
        chk(40'(n_start), 40'(s + 1));
        chk({3'h0, last_job},
            {3'h0, CMD_PROGRAM, 13'h0004, 16'h1234});
        wait_cc();
        chk(rd, 40'hc0);
    endtask
    // second job waits in the buffer, completion only after both
    task automatic t_chain();
        int s;
        int i;
        s = n_start;
        dly <= 8'd30;
        launch(16'h8020, 16'h0001, CMD_PROGRAM);
        launch(16'h8024, 16'h0002, CMD_PROGRAM);
        for (i = 0; i < 200 && n_start < s + 2; i++) begin
            @(posedge clk_i);
        end
        chk(40'(n_start), 40'(s + 2));
        rdc(A_ST, 40'h80);
        wait_cc();
        chk(rd, 40'hc0);
        chk({24'h0, last_job.data}, 40'h2);
    endtask
    task automatic t_codes();
        int s;
        blank <= 1'b1;
        dly <= 8'd4;
        foreach (codes[k]) begin
            s = n_start;
            wb(1'b1, 16'h8000, 32'h0);
            wb(1'b1, A_CM, {24'h0, codes[k]});
            rdc(A_CM, {32'h0, codes[k] & 8'h65});
            wb(1'b1, A_ST, 32'h80);
            if (k < 4) begin
                wait_cc();
                chk(rd, (k == 0) ? 40'hc4 : 40'hc0);
                chk(40'(n_start), 40'(s + 1));
            end else begin
                wb(1'b0, A_ST, 32'h0);
                chk(rd & 40'hbf, 40'h90);
                chk(40'(n_start), 40'(s));
                wb(1'b1, A_ST, 32'h10);
                rdc(A_ST, 40'hc0);
            end
        end
    endtask
    // abort mid-sequence, then both error flags cleared in one write
    task automatic t_errors();
        int s;
        prot <= 1'b1;
        launch(16'h8000, 16'h0, CMD_SECTOR);
        prot <= 1'b0;
        wb(1'b0, A_ST, 32'h0);
        chk(rd & 40'hbf, 40'ha0);
        wb(1'b1, 16'h8000, 32'h0);
        wb(1'b1, A_ST, 32'h00);
        wb(1'b0, A_ST, 32'h0);
        chk(rd & 40'hbf, 40'hb0);
        s = n_start;
        launch(16'h8000, 16'h0, CMD_PROGRAM);
        wb(1'b1, A_ST, 32'h00);
        wb(1'b0, A_ST, 32'h0);
        chk(rd & 40'hbf, 40'hb0);
        chk(40'(n_start), 40'(s));
        wb(1'b1, A_ST, 32'h30);
        rdc(A_ST, 40'hc0);
    endtask
    task automatic t_special();
        int s;
        spec <= 1'b1;
        blank <= 1'b0;
        dly <= 8'd40;
        launch(16'h8000, 16'h0, CMD_VERIFY);
        rdc(A_ST, 40'h80);
        wait_cc();
        chk(rd, 40'hc3);
        spec <= 1'b0;
        rdc(A_ST, 40'hc0);
        spec <= 1'b1;
        s = n_start;
        launch(16'h8000, 16'h0, CMD_PROGRAM);
        wb(1'b1, A_ST, 32'h01);
        wb(1'b0, A_ST, 32'h0);
        chk(rd & 40'hbf, 40'h83);
        chk(40'(n_start), 40'(s));
        wb(1'b1, A_ST, 32'h02);
        rdc(A_ST, 40'hc1);
        spec <= 1'b0;
    endtask
    // irq lines follow flag and enable; a cpu stop mid-job errors
    task automatic t_irq_stop();
        wb(1'b1, A_CF, 32'hc0);
        rdc(A_CF, 40'hc0);
        chk({38'h0, be_irq_o, cc_irq_o}, 40'h3);
        dly <= 8'd30;
        launch(16'h8000, 16'h0, CMD_PROGRAM);
        rdc(A_ST, 40'h80);
        chk({38'h0, be_irq_o, cc_irq_o}, 40'h2);
        stop <= 1'b1;
        @(posedge clk_i);
        stop <= 1'b0;
        wait_cc();
        chk(rd & 40'hbf, 40'h90);
        chk({38'h0, be_irq_o, cc_irq_o}, 40'h3);
        wb(1'b1, A_ST, 32'h10);
        wb(1'b1, A_CF, 32'h00);
        rdc(A_ST, 40'hc0);
        chk({38'h0, be_irq_o, cc_irq_o}, 40'h0);
    endtask

    // main sequence and watchdog
    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_prog();
        t_chain();
        t_codes();
        t_errors();
        t_special();
        t_irq_stop();
        wrap_up();
    end
    initial begin
        repeat (40000) @(posedge clk_i);
        n_fail++;
        wrap_up();
    end
endmodule
`default_nettype wire
